// ### hw/irqeb_bank.sv
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "irqeb_params.svh"
module irqeb_bank
   import irqeb_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [11:0] src_event,
   output logic             irq_req
);
   // ==========================================
   // Source events, one-cycle pulses or levels, bit order
   // [11] overcurrent_guard [10] low_voltage [9] group one [8] filtered_input_pin
   // [7..4] groups five..two  [3] time base [2] group six [1] eeprom [0] serial
   // Sources run on this clock, so they need no synchroniser

   // ==========================================
   // Storage and strobes
   irqeb_ctrl_t   ctrl_one_q;
   irqeb_ctrl_t   ctrl_one_d;
   irqeb_ctrl_t   ctrl_two_q;
   irqeb_ctrl_t   ctrl_two_d;
   irqeb_ctrl_t   ctrl_three_q;
   irqeb_ctrl_t   ctrl_three_d;
   logic          global_irq_enable_q;
   logic          global_irq_enable_d;
   irqeb_aphase_t aph_q;
   irqeb_aphase_t aph_d;
   logic          hreadyout_q;
   logic          hresp_q;
   logic          rd_take;
   logic [7:0]    rd_addr;
   logic [31:0]   rdata_d;
   logic          irq_d;
   logic          wr_one;
   logic          wr_two;
   logic          wr_three;
   logic          wr_glob;
   logic [7:0]    wbyte;
   logic [3:0]    ev_one;
   logic [3:0]    ev_two;
   logic [3:0]    ev_three;

   // ==========================================
   // Helpers
   // Word address of a bus address; byte lanes are not decoded
   function automatic logic [7:0] word_addr(input logic [31:0] a);
      return {a[`IRQEB_ADDR_MSB:`IRQEB_ADDR_LSB], `IRQEB_ADDR_PAD};
   endfunction

   // Data-phase write aimed at one register
   function automatic logic wr_hit(
      input irqeb_aphase_t ap,
      input logic [7:0]    reg_addr
   );
      return ap.valid && ap.write && (ap.addr == reg_addr);
   endfunction

   // Next value of a control register
   function automatic irqeb_ctrl_t upd(
      input irqeb_ctrl_t cur,
      input logic        wr,
      input logic [7:0]  wd,
      input logic [3:0]  ev
   );
      irqeb_ctrl_t n;
      n = cur;
      if (wr)
      begin
         n = irqeb_ctrl_t'(wd);
      end
      // Hardware set wins over a software clear in the same cycle
      n.flag = n.flag | ev;
      return n;
   endfunction

   // Any source of one register both flagged and enabled
   function automatic logic pending(input irqeb_ctrl_t c);
      return |(c.flag & c.enable);
   endfunction

   // Byte register zero-extended onto the data bus
   function automatic logic [31:0] byte_word(input logic [7:0] v);
      return 32'(v);
   endfunction

   // Single bit zero-extended onto the data bus
   function automatic logic [31:0] bit_word(input logic v);
      return 32'(v);
   endfunction

   // ==========================================
   // Bus slave: zero wait states, always OKAY
   // Ready and response come from flops so every output is registered
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         hreadyout_q <= `IRQEB_HREADY_IDLE;
         hresp_q     <= `IRQEB_HRESP_OKAY;
      end
      else
      begin
         hreadyout_q <= `IRQEB_HREADY_IDLE;
         hresp_q     <= `IRQEB_HRESP_OKAY;
      end
   end

   assign hreadyout = hreadyout_q;
   assign hresp     = hresp_q;

   // ==========================================
   // Address phase, held for the data phase
   always_comb
   begin
      aph_d = aph_q;
      if (hready)
      begin
         aph_d.valid = hsel && htrans[`IRQEB_HTRANS_ACT_BIT];
         aph_d.write = hwrite;
         aph_d.addr  = word_addr(haddr);
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         aph_q <= '0;
      end
      else
      begin
         aph_q <= aph_d;
      end
   end

   // ==========================================
   // Write strobes and event slices
   assign wbyte    = hwdata[`IRQEB_BYTE_MSB:`IRQEB_BYTE_LSB];
   assign wr_one   = wr_hit(aph_q, `IRQEB_ADDR_CTRL_ONE);
   assign wr_two   = wr_hit(aph_q, `IRQEB_ADDR_CTRL_TWO);
   assign wr_three = wr_hit(aph_q, `IRQEB_ADDR_CTRL_THREE);
   assign wr_glob  = wr_hit(aph_q, `IRQEB_ADDR_GLOBAL);
   assign ev_one   = src_event[`IRQEB_SRC_ONE_MSB:`IRQEB_SRC_ONE_LSB];
   assign ev_two   = src_event[`IRQEB_SRC_TWO_MSB:`IRQEB_SRC_TWO_LSB];
   assign ev_three = src_event[`IRQEB_SRC_THREE_MSB:`IRQEB_SRC_THREE_LSB];

   // ==========================================
   // Read path
   // Data is captured at the address edge so it stands through the data phase;
   // a read right behind a write to the same register returns the old value
   assign rd_take = hready && hsel && htrans[`IRQEB_HTRANS_ACT_BIT] && !hwrite;
   assign rd_addr = word_addr(haddr);

   always_comb
   begin
      rdata_d = hrdata;
      if (rd_take)
      begin
         unique case (rd_addr)
            `IRQEB_ADDR_CTRL_ONE:
            begin
               rdata_d = byte_word(ctrl_one_q);
            end
            `IRQEB_ADDR_CTRL_TWO:
            begin
               rdata_d = byte_word(ctrl_two_q);
            end
            `IRQEB_ADDR_CTRL_THREE:
            begin
               rdata_d = byte_word(ctrl_three_q);
            end
            `IRQEB_ADDR_GLOBAL:
            begin
               rdata_d = bit_word(global_irq_enable_q);
            end
            `IRQEB_ADDR_STATUS:
            begin
               rdata_d = bit_word(irq_req);
            end
            default:
            begin
               // Unmapped words read as zero
               rdata_d = `IRQEB_RDATA_RESET;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         hrdata <= `IRQEB_RDATA_RESET;
      end
      else
      begin
         hrdata <= rdata_d;
      end
   end

   // ==========================================
   // Control register one: overcurrent, low voltage, group one, filtered pin
   always_comb
   begin
      ctrl_one_d = upd(ctrl_one_q, wr_one, wbyte, ev_one);
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_one_q <= `IRQEB_REG_RESET;
      end
      else
      begin
         // Flags stay set until software writes them to zero
         ctrl_one_q <= ctrl_one_d;
      end
   end

   // ==========================================
   // Control register two: groups five..two
   always_comb
   begin
      ctrl_two_d = upd(ctrl_two_q, wr_two, wbyte, ev_two);
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_two_q <= `IRQEB_REG_RESET;
      end
      else
      begin
         ctrl_two_q <= ctrl_two_d;
      end
   end

   // ==========================================
   // Control register three: time base, group six, eeprom, serial
   always_comb
   begin
      ctrl_three_d = upd(ctrl_three_q, wr_three, wbyte, ev_three);
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_three_q <= `IRQEB_REG_RESET;
      end
      else
      begin
         ctrl_three_q <= ctrl_three_d;
      end
   end

   // ==========================================
   // Global enable
   always_comb
   begin
      global_irq_enable_d = global_irq_enable_q;
      if (wr_glob)
      begin
         global_irq_enable_d = wbyte[`IRQEB_GLOBAL_BIT];
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         global_irq_enable_q <= 1'h0;
      end
      else
      begin
         global_irq_enable_q <= global_irq_enable_d;
      end
   end

   // ==========================================
   // Request toward the core
   // Registered, so it trails a flag or enable change by one cycle
   always_comb
   begin
      irq_d = pending(ctrl_one_q) || pending(ctrl_two_q) || pending(ctrl_three_q);
      irq_d = irq_d && global_irq_enable_q;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         irq_req <= 1'h0;
      end
      else
      begin
         irq_req <= irq_d;
      end
   end

   // ==========================================
   // Notes for users
   // Software must clear a serviced flag itself; an event in the same
   // cycle as that clear keeps the flag set, so no request is lost.
   // Unmapped words read zero and ignore writes; upper data bits read zero.
   // Transfer size is not decoded: every access is taken as a whole word.
endmodule

// ### hw/irqeb_params.svh
// Overview of operation
// - Register one upper nibble holds four request flags
// - Register one bits 3..0 enable those sources
// - Register one bit 0 enables filtered pin
// - Register two bits 7..4 flag groups five..two
// - Register two bits 3..0 enable groups five..two
// - Register three: time base flag 7, enable 3
// - Register three: group six flag 6, enable 2
// - Register three: eeprom flag 5, enable 1
// - Register three: serial flag 4, enable 0
// - All bits software read/write, reset to zero
// - Global enable gates every source off
`ifndef IRQEB_PARAMS_SVH
`define IRQEB_PARAMS_SVH
// ==========================================
// Register byte addresses
`define IRQEB_ADDR_CTRL_ONE   8'h00
`define IRQEB_ADDR_CTRL_TWO   8'h04
`define IRQEB_ADDR_CTRL_THREE 8'h08
`define IRQEB_ADDR_GLOBAL     8'h0c
`define IRQEB_ADDR_STATUS     8'h10
// ==========================================
// Field layout and reset values
`define IRQEB_FLAG_MSB        7
`define IRQEB_FLAG_LSB        4
`define IRQEB_EN_MSB          3
`define IRQEB_EN_LSB          0
`define IRQEB_REG_RESET       8'h00
`define IRQEB_ADDR_MSB        7
`define IRQEB_ADDR_LSB        2
`define IRQEB_ADDR_PAD        2'h0
// ==========================================
// Bus encodings and levels
`define IRQEB_HTRANS_ACT_BIT  1
`define IRQEB_HREADY_IDLE     1'h1
`define IRQEB_HRESP_OKAY      1'h0
`define IRQEB_RDATA_RESET     32'h0000_0000
`define IRQEB_BYTE_MSB        7
`define IRQEB_BYTE_LSB        0
`define IRQEB_GLOBAL_BIT      0
// ==========================================
// Source event slices
`define IRQEB_SRC_ONE_MSB     11
`define IRQEB_SRC_ONE_LSB     8
`define IRQEB_SRC_TWO_MSB     7
`define IRQEB_SRC_TWO_LSB     4
`define IRQEB_SRC_THREE_MSB   3
`define IRQEB_SRC_THREE_LSB   0
`endif

// ### hw/irqeb_pkg.sv
package irqeb_pkg;
   // ==========================================
   // AHB-Lite constants and carriers
   typedef enum logic [1:0]
   {
      IRQEB_HTRANS_IDLE   = 2'b00,
      IRQEB_HTRANS_BUSY   = 2'b01,
      IRQEB_HTRANS_NONSEQ = 2'b10,
      IRQEB_HTRANS_SEQ    = 2'b11
   } irqeb_htrans_t;

   typedef struct packed
   {
      logic [3:0] flag;
      logic [3:0] enable;
   } irqeb_ctrl_t;

   typedef struct packed
   {
      logic       valid;
      logic       write;
      logic [7:0] addr;
   } irqeb_aphase_t;
endpackage

// ### sim/irqeb_bank_sva.sv
`timescale 1ns/1ns
module irqeb_bank_sva
(
   input wire logic        clk, rst, hsel, hwrite, hresp, hreadyout, irq_req,
   input wire logic [31:0] haddr, hwdata, hrdata,
   input wire logic [1:0]  htrans,
   input wire logic [11:0] src_event
);
   // ======
   // Checks
   wire logic rt = hsel && htrans == 2'h2 && !hwrite;
   wire logic wt = hsel && htrans == 2'h2 && hwrite;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_goff; wt && haddr[7:0] == 8'h0c ##1 !hwdata[0]; endsequence
   property p_rdy; hreadyout && !hresp; endproperty
   a_rdy: assert property (p_rdy) else $error("stall");
   property p_hi; rt |=> hrdata[31:8] == 24'h0; endproperty
   a_hi: assert property (p_hi) else $error("high bits");
   property p_glob; rt && haddr[7:0] == 8'h0c |=> hrdata[31:1] == 31'h0; endproperty
   a_glob: assert property (p_glob) else $error("global");
   property p_gap; rt && haddr[7:0] == 8'h14 |=> hrdata == 32'h0; endproperty
   a_gap: assert property (p_gap) else $error("gap");
   property p_hold; !rt |=> $stable(hrdata); endproperty
   a_hold: assert property (p_hold) else $error("moved");
   property p_rise; $rose(irq_req) |-> $past(|src_event, 2) || $past(wt, 3); endproperty
   a_rise: assert property (p_rise) else $error("spurious");
   property p_fall; $fell(irq_req) |-> $past(wt, 3); endproperty
   a_fall: assert property (p_fall) else $error("dropped");
   property p_goff; s_goff |-> ##2 !irq_req; endproperty
   a_goff: assert property (p_goff) else $error("ungated");
endmodule
bind irqeb_bank irqeb_bank_sva u_sva (.*);

// ### sim/irqeb_bank_tb.sv
`timescale 1ns/1ns
module irqeb_bank_tb;
   logic        clk = 0, rst = 1, hsel = 0, hwrite = 0, go = 0, rdp = 0, hready, hresp, irq_req;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, q[$];
   logic [1:0]  htrans = '0;
   logic [11:0] src_event;
   logic [3:0]  idx = '0;
   int          n_mismatch = 0, comparisons = 0, cyc = 0, r, b;
   irqeb_bank uut (.*, .hsize(3'h2), .hreadyout(hready));
   irqeb_src src (.*);
   // ======
   // Bus and checks
   initial forever #5 clk = ~clk;
   always @(posedge clk) if (rdp && hready) chk(hrdata, q.pop_front());
   always @(posedge clk) if (++cyc > 9999) begin n_mismatch++; wrap_up; end
   task automatic chk(logic [31:0] s, e);
      comparisons++;
      if (s !== e) begin n_mismatch++; $display("[FAIL] %0t %h not %h", $time, s, e); end
   endtask
   task bus(logic w, int a, logic [31:0] d);
      {hsel, hwrite, haddr, htrans} <= {1'b1, w, 32'(a), 2'h2};
      do @(posedge clk); while (hready !== 1'b1);
      {htrans, hwdata, rdp} <= {2'h0, d, !w};
      do @(posedge clk); while (hready !== 1'b1);
      rdp <= 0;
   endtask
   task rd(int a, logic [31:0] e); q.push_back(e); bus(0, a, 0); endtask
   task wi(logic [31:0] e); repeat (2) @(negedge clk); chk(32'(irq_req), e); @(posedge clk); endtask
   task wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      void'($urandom(3283));
      repeat (16) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      bus(1, 8'h14, '1);
      for (int a = 0; a < 24; a += 4) rd(a, 0);
      $display("reset test done");
      for (int i = 0; i < 15; i++)
      begin
         b = i < 12 ? $urandom : 0;
         bus(1, i % 3 * 4, b);
         rd(i % 3 * 4, b & 8'hff);
      end
      $display("read write test done");
      for (int k = 0; k < 12; k++)
      begin
         r = 8 - k / 4 * 4;
         b = k % 4;
         {idx, go} <= {4'(k), 1'b1};
         @(posedge clk) go <= 0;
         @(posedge clk);
         rd(r, 8'h10 << b);
         bus(1, r, 8'h11 << b);
         bus(1, 8'h0c, 1);
         wi(1);
         rd(8'h10, 1);
         rd(8'h0c, 1);
         bus(1, 8'h0c, 0);
         wi(0);
         bus(1, 8'h0c, 1);
         bus(1, r, 8'h01 << b);
         wi(0);
         bus(1, r, 0);
         bus(1, 8'h0c, 0);
      end
      $display("event test done");
      wrap_up;
   end
endmodule

// ### sim/irqeb_src.sv
`timescale 1ns/1ns
module irqeb_src
(
   input wire logic       clk, go,
   input wire logic [3:0] idx,
   output logic    [11:0] src_event = '0
);
   // One-cycle pulses: the hardest case, a level would mask a lost set
   always @(posedge clk) src_event <= go ? 12'h1 << idx : 12'h0;
endmodule
